// *** rtl/cbss_pkg.sv ***
package cbss_pkg;

    localparam logic [7:0]  CBSS_STATUS_DW_OFS = 8'h14;
    localparam logic [7:0]  CBSS_BUSNUM_DW_OFS = 8'h18;
    localparam int          CBSS_STATUS_LSB    = 16;
    localparam logic [15:0] CBSS_STATUS_RST    = 16'h0200;
    localparam logic [7:0]  CBSS_BUSNUM_RST    = 8'h00;
    localparam logic [1:0]  CBSS_DEVSEL_MEDIUM = 2'h1;
    localparam int          CBSS_BIT_PARITY    = 15;
    localparam int          CBSS_BIT_SERR      = 14;
    localparam int          CBSS_BIT_MABORT    = 13;
    localparam int          CBSS_BIT_TA_RCVD   = 12;
    localparam int          CBSS_BIT_TA_SIG    = 11;
    localparam int          CBSS_BIT_DPAR      = 8;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } cbss_cfg_s;

    typedef struct packed {
        logic parity;
        logic mabort;
        logic ta_rcvd;
        logic ta_sig;
        logic perr;
        logic master_data;
    } cbss_evt_s;

    typedef struct packed {
        logic       valid;
        logic [7:0] bus;
        logic [7:0] cardbus_bus;
        logic [7:0] subordinate_bus;
    } cbss_fwd_s;

endpackage : cbss_pkg

// *** rtl/cbss_top.sv ***
`timescale 1ns/10ps
module cbss_top (
    // Clock and reset
    input  wire logic               clock,
    input  wire logic               reset,
    // Configuration access
    input  wire cbss_pkg::cbss_cfg_s cfg,
    output logic [31:0]             cfg_rdata_ff,
    output logic                    cfg_rvalid_ff,
    // CardBus events and pins
    input  wire cbss_pkg::cbss_evt_s evt,
    input  wire logic               parity_resp_en,
    input  wire logic               cserr_n_in,
    output logic                    cserr_n_out_ff,
    output logic                    cserr_n_oe_ff,
    // Configuration forwarding decision
    input  wire cbss_pkg::cbss_fwd_s fwd,
    output logic                    fwd_type0_ff,
    output logic                    fwd_type1_ff,
    output logic                    upstream_hit_ff,
    output logic [7:0]              upstream_bus_number_ff
);
    import cbss_pkg::*;

    logic [15:11] sticky_ff;
    logic         dpar_ff;
    logic         serr_meta_ff;
    logic         serr_sync_ff;
    logic [4:0]   set_hi;
    logic [4:0]   clr_hi;
    logic         set_dpar;
    logic         clr_dpar;
    logic         wr_status;
    logic [15:0]  status_now;

    function automatic logic [15:0] status_word(input logic [15:11] s,
                                                input logic d);
        status_word = {s, CBSS_DEVSEL_MEDIUM, d, 8'h00};
    endfunction : status_word

    ////////////////////////////////////////////////////////////////////////
    // CSERR pin: synchronise the card's level, never drive it
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            serr_meta_ff <= 1'b1;
            serr_sync_ff <= 1'b1;
        end else begin
            serr_meta_ff <= cserr_n_in;
            serr_sync_ff <= serr_meta_ff;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            cserr_n_out_ff <= 1'b1;
            cserr_n_oe_ff  <= 1'b0;
        end else begin
            cserr_n_out_ff <= 1'b1;
            cserr_n_oe_ff  <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky status bits
    assign wr_status = cfg.wr && (cfg.addr[7:2] == CBSS_STATUS_DW_OFS[7:2]);
    assign set_hi = {evt.parity,
                     !serr_sync_ff,
                     evt.mabort,
                     evt.ta_rcvd,
                     evt.ta_sig};
    assign set_dpar = evt.perr && evt.master_data && parity_resp_en;
    assign clr_hi = (wr_status && cfg.be[3]) ? cfg.wdata[31:27] : 5'h00;
    assign clr_dpar = wr_status && cfg.be[3] && cfg.wdata[24];
    assign status_now = status_word(sticky_ff, dpar_ff);

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            sticky_ff <= CBSS_STATUS_RST[15:11];
            dpar_ff   <= CBSS_STATUS_RST[8];
        end else begin
            sticky_ff <= (sticky_ff & ~clr_hi) | set_hi;
            dpar_ff   <= (dpar_ff & ~clr_dpar) | set_dpar;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Upstream bus number register
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            upstream_bus_number_ff <= CBSS_BUSNUM_RST;
        end else if (cfg.wr && cfg.be[0]
                     && cfg.addr[7:2] == CBSS_BUSNUM_DW_OFS[7:2]) begin
            upstream_bus_number_ff <= cfg.wdata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            cfg_rdata_ff  <= 32'h0000_0000;
            cfg_rvalid_ff <= 1'b0;
        end else begin
            cfg_rvalid_ff <= cfg.rd;
            if (!cfg.rd) begin
                cfg_rdata_ff <= 32'h0000_0000;
            end else if (cfg.addr[7:2] == CBSS_STATUS_DW_OFS[7:2]) begin
                cfg_rdata_ff <= {status_now, 16'h0000};
            end else if (cfg.addr[7:2] == CBSS_BUSNUM_DW_OFS[7:2]) begin
                cfg_rdata_ff <= {8'h00, fwd.subordinate_bus,
                                 fwd.cardbus_bus, upstream_bus_number_ff};
            end else begin
                cfg_rdata_ff <= 32'h0000_0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Forwarding decision
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            fwd_type0_ff    <= 1'b0;
            fwd_type1_ff    <= 1'b0;
            upstream_hit_ff <= 1'b0;
        end else begin
            fwd_type0_ff    <= fwd.valid
                               && fwd.bus == fwd.cardbus_bus;
            fwd_type1_ff    <= fwd.valid && fwd.bus > fwd.cardbus_bus
                               && fwd.bus <= fwd.subordinate_bus;
            upstream_hit_ff <= fwd.valid
                               && fwd.bus == upstream_bus_number_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    chk_parity_sets: assert property (@(posedge clock) disable iff (reset)
        evt.parity |=> sticky_ff[15])
        else $error("parity event did not set bit 15");
    chk_serr_sets: assert property (@(posedge clock) disable iff (reset)
        !serr_sync_ff |=> sticky_ff[14])
        else $error("card system error did not set bit 14");
    chk_cserr_never: assert property (@(posedge clock) disable iff (reset)
        !cserr_n_oe_ff)
        else $error("bridge drove CSERR");
    chk_mabort_sets: assert property (@(posedge clock) disable iff (reset)
        evt.mabort |=> sticky_ff[13])
        else $error("master abort did not set bit 13");
    chk_ta_rcvd_sets: assert property (@(posedge clock) disable iff (reset)
        evt.ta_rcvd |=> sticky_ff[12])
        else $error("received target abort did not set bit 12");
    chk_ta_sig_sets: assert property (@(posedge clock) disable iff (reset)
        evt.ta_sig |=> sticky_ff[11])
        else $error("signaled target abort did not set bit 11");
    chk_status_fixed: assert property (@(posedge clock) disable iff (reset)
        cfg.rd && cfg.addr[7:2] == CBSS_STATUS_DW_OFS[7:2]
        |=> cfg_rdata_ff[26:25] == 2'b01 && cfg_rdata_ff[23:16] == 8'h00)
        else $error("fixed status bits read wrong");
    chk_dpar_gate: assert property (@(posedge clock) disable iff (reset)
        !dpar_ff && !(evt.perr && evt.master_data && parity_resp_en)
        |=> !dpar_ff)
        else $error("bit 8 set without its conditions");
    chk_busnum_write: assert property (@(posedge clock) disable iff (reset)
        cfg.wr && cfg.be[0] && cfg.addr == CBSS_BUSNUM_DW_OFS
        |=> upstream_bus_number_ff == $past(cfg.wdata[7:0]))
        else $error("upstream bus number not written");
    chk_clear_one: assert property (@(posedge clock) disable iff (reset)
        wr_status && cfg.be[3] && cfg.wdata[31] && !evt.parity
        |=> !sticky_ff[15])
        else $error("write one did not clear bit 15");
    chk_set_wins: assert property (@(posedge clock) disable iff (reset)
        clr_hi[2] && evt.mabort |=> sticky_ff[13])
        else $error("clear beat a same-cycle event");
    chk_fwd_type1: assert property (@(posedge clock) disable iff (reset)
        fwd.valid && fwd.bus > fwd.cardbus_bus
        && fwd.bus <= fwd.subordinate_bus |=> fwd_type1_ff && !fwd_type0_ff)
        else $error("subordinate range not forwarded");

endmodule : cbss_top

// *** sim/cardbus_secondary_status_tb.sv ***
`timescale 1ns/10ps
module cardbus_secondary_status_tb;
    import cbss_pkg::*;
    logic        clock, reset, parity_resp_en, serr_req, card_n, pin_n;
    logic        rvalid, cs_out, cs_oe, t0, t1, hit;
    logic [7:0]  ubn, x;
    logic [31:0] rdata, exp;
    cbss_cfg_s   cfg;
    cbss_evt_s   evt, ev;
    cbss_fwd_s   fwd;
    int          mismatches, total_checks, st, ub, i;
    ////////////////////////////////////////////////////////////
    cbss_top DUT (.clock(clock), .reset(reset), .cfg(cfg),
        .cfg_rdata_ff(rdata), .cfg_rvalid_ff(rvalid), .evt(evt),
        .parity_resp_en(parity_resp_en), .cserr_n_in(pin_n),
        .cserr_n_out_ff(cs_out), .cserr_n_oe_ff(cs_oe), .fwd(fwd),
        .fwd_type0_ff(t0), .fwd_type1_ff(t1), .upstream_hit_ff(hit),
        .upstream_bus_number_ff(ubn));
    cbss_card_model card (.serr_req(serr_req), .cserr_n(card_n));
    // Wired level of the open-drain line
    assign pin_n = card_n & (cs_oe ? cs_out : 1'b1);
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    function automatic logic [7:0] nxt_rand(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : nxt_rand
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        total_checks++;
        if (seen !== want) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, want);
        end
    endtask : chk
    task automatic print_verdict;
        $display("checks=%0d mismatches=%0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    // One access with events, then idle; model updated at the access edge
    task automatic cyc(input cbss_evt_s e, input logic w, input logic r,
                       input logic [7:0] a, input logic [3:0] b,
                       input logic [31:0] d);
        logic [15:0] set, clr;
        logic [2:0]  fx;
        @(negedge clock);
        evt = e;
        cfg = '{wr: w, rd: r, addr: a, be: b, wdata: d};
        fwd.valid = !w;
        exp = (a[7:2] == 6'h05) ? {st[15:0], 16'h0000} :
              (a[7:2] == 6'h06) ? {8'h00, fwd.subordinate_bus,
                                   fwd.cardbus_bus, ub[7:0]} : 32'h0;
        fx = {fwd.bus == fwd.cardbus_bus, fwd.bus > fwd.cardbus_bus &&
              fwd.bus <= fwd.subordinate_bus, fwd.bus == ub[7:0]};
        set = {e.parity, 1'b0, e.mabort, e.ta_rcvd, e.ta_sig, 2'b00,
               e.perr & e.master_data & parity_resp_en, 8'h00};
        clr = (w && a[7:2] == 6'h05 && b[3]) ? {d[31:24], 8'h00} : 16'h0;
        st = (st & ~{16'h0, clr & 16'hf900}) | set | 16'h0200;
        if (w && a[7:2] == 6'h06 && b[0])
            ub = d[7:0];
        @(negedge clock);
        evt = '0;
        cfg = '0;
        if (!w) chk({t0, t1, hit}, fx);
        chk(rvalid, r);
        if (r) chk(rdata, exp);
        if (r) chk(rdata[25:16], exp[25:16]);
        chk(ubn, ub);
        chk({cs_oe, cs_out}, 2'b01);
    endtask : cyc
    ////////////////////////////////////////////////////////////
    initial begin
        #200000;
        mismatches++;
        print_verdict();
    end
    initial begin
        mismatches = 0;
        total_checks = 0;
        st = 16'h0200;
        ub = 0;
        x = 8'h54;
        reset = 1'b1;
        cfg = '0;
        evt = '0;
        fwd = '0;
        parity_resp_en = 1'b0;
        serr_req = 1'b0;
        repeat (2) @(posedge clock);
        @(negedge clock);
        reset = 1'b0;
        cyc('0, 1'b0, 1'b1, 8'h14, 4'h0, 32'h0);
        cyc('0, 1'b0, 1'b1, 8'h18, 4'h0, 32'h0);
        for (i = 0; i < 400; i++) begin
            x = nxt_rand(x);
            parity_resp_en = x[6];
            fwd.cardbus_bus = x;
            fwd.subordinate_bus = x + {5'h0, x[7:5]};
            x = nxt_rand(x);
            fwd.bus = x[7] ? ub[7:0] : fwd.cardbus_bus + {4'h0, x[3:0]} - 8'h02;
            x = nxt_rand(x);
            ev = x[7] ? x[5:0] : '0;
            x = nxt_rand(x);
            case (x[1:0])
                2'h0: cyc(ev, 1'b0, 1'b1, 8'h14, 4'h0, 32'h0);
                2'h1: cyc(ev, 1'b1, 1'b0, 8'h14, {x[4], 3'h0}, {x, 24'h0});
                2'h2: cyc(ev, 1'b1, 1'b0, x[3] ? 8'h18 : 8'h1c,
                          {3'h0, x[2]}, {24'h0, x});
                default: cyc(ev, 1'b0, 1'b1, x[7] ? 8'h1c : 8'h18, 4'h0, 0);
            endcase
        end
        // Card holds the system error line low, then releases it
        serr_req = 1'b1;
        repeat (5) cyc('0, 1'b0, 1'b0, 8'h00, 4'h0, 32'h0);
        serr_req = 1'b0;
        repeat (3) cyc('0, 1'b0, 1'b0, 8'h00, 4'h0, 32'h0);
        st = st | 16'h4000;
        cyc('0, 1'b0, 1'b1, 8'h14, 4'h0, 32'h0);
        cyc('0, 1'b1, 1'b0, 8'h14, 4'h8, 32'h4000_0000);
        cyc('0, 1'b0, 1'b1, 8'h14, 4'h0, 32'h0);
        print_verdict();
    end
endmodule : cardbus_secondary_status_tb

// *** sim/cbss_card_model.sv ***
`timescale 1ns/10ps
module cbss_card_model (
    // Card request and pin
    input  wire logic serr_req,
    output logic      cserr_n
);
    // Only the card pulls the line low; the pull-up returns it high
    assign cserr_n = serr_req ? 1'b0 : 1'b1;
endmodule : cbss_card_model
